/* leader_drive_model.sv */
// Purpose: Behavioural leading drive encoder feeding the follower core
// Assumes: Position advances by the set speed every clock
// Notes:   Speed follows the bench setting one clock late
`timescale 1ns/1ps
module leader_drive_model
    import sync_follower_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    input  wire logic signed [SPD_W-1:0] speed_set,
    output axis_t                        leader
);
    // =========================================================================
    // Speed and position integration
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            leader <= '0;
        end else begin
            leader.speed    <= speed_set;
            leader.position <= leader.position + 64'(speed_set);
        end
    end
endmodule : leader_drive_model

/* ramp_step.sv */
// Purpose: Moves a speed value toward a target by at most one ramp step
// Assumes: Step is positive
// Notes:   Used for coupling speed match and angle close, and decoupling brake
`timescale 1ns/1ps
module ramp_step
    import sync_follower_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic signed [W-1:0] cur,
    input  wire logic signed [W-1:0] target,
    input  wire logic signed [W-1:0] step,
    output logic signed [W-1:0]      next_val,
    output logic                     at_target
);
    wire logic signed [W:0] cur_x_w  = {cur[W-1], cur};
    wire logic signed [W:0] tgt_x_w  = {target[W-1], target};
    wire logic signed [W:0] step_x_w = {step[W-1], step};
    wire logic signed [W:0] diff_w   = tgt_x_w - cur_x_w;
    wire logic              up_w     = diff_w > step_x_w;
    wire logic              dn_w     = diff_w < -step_x_w;

    assign next_val  = up_w ? W'(cur + step) : (dn_w ? W'(cur - step) : target);
    assign at_target = !up_w && !dn_w;
endmodule : ramp_step

/* sync_follower_main_state.sv */
// Purpose: Main state machine of a follower drive locked to a leading drive
// Assumes: One sample per SAMPLE_CYCLES clocks; all inputs synchronous
// Notes:   Sub-machines for position coupling and offset are external; the stop ramp is internal
//
// Notes on behaviour
// - Main state 0..5 is kept and readable in the state register.
// - State 0 runs speed control at the free-run speed.
// - State 1 holds the position latched on entry.
// - State 2 couples; coupling option bit 12 picks time or position control.
// - State 3 follows the leader rigidly at the same angle.
// - State 4 applies offset; offset option bit 12 picks time or position.
// - State 5 decouples, braking along the stop ramp.
// - Option bit 0 in state 1 jumps to target position without ramp.
// - Option bit 1 suppresses lag monitoring in state 3, non-positioning, non-sync ramp.
// - Option bit 2 scales corrections by follower gear factor before adding.
// - Option bit 3 keeps feedforward on zero-point set, else cancels it outside state 0.
// - Time coupling removes the 64-bit difference via the sync speed.
// - Time coupling: speed match first, then lag distance closed to zero.
// - Sync speed and sync ramp come from two configuration parameters.
`timescale 1ns/1ps
module sync_follower_main_state
    import sync_follower_pkg::*;
#(
    parameter int SAMPLE_DIV = SAMPLE_CYCLES
) (
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    // Register access
    input  wire logic                    state_wr,
    input  wire logic [WORD_W-1:0]       state_wdata,
    output logic [WORD_W-1:0]            sync_main_state,
    input  wire logic                    option_wr,
    input  wire logic [WORD_W-1:0]       option_wdata,
    output logic [WORD_W-1:0]            sync_option_word,
    // Configuration
    input  wire logic signed [SPD_W-1:0] free_run_speed,
    input  wire logic signed [POS_W-1:0] target_position,
    input  wire logic [WORD_W-1:0]       coupling_option_word,
    input  wire logic [WORD_W-1:0]       offset_option_word,
    input  wire logic signed [SPD_W-1:0] sync_speed_param,
    input  wire logic signed [SPD_W-1:0] sync_ramp_param,
    input  wire logic signed [SPD_W-1:0] stop_ramp,
    input  wire logic signed [15:0]      follower_gear_factor,
    input  wire logic                    positioning_mode,
    input  wire logic                    sync_ramp_type,
    // Leader and follower feedback
    input  wire axis_t                   leader,
    input  wire axis_t                   follower,
    input  wire logic                    correction_valid,
    input  wire logic signed [SPD_W-1:0] correction_value,
    input  wire logic                    zero_point_set,
    input  wire logic                    sub_machine_done,
    // Outputs
    output drive_cmd_t                   drive_cmd,
    output logic                         pos_ctrl_coupling,
    output logic                         pos_ctrl_offset,
    output logic signed [POS_W-1:0]      lag_distance,
    output logic [1:0]                   couple_step
);

    // =========================================================================
    // Registers
    main_state_t             state_reg;
    main_state_t             state_next;
    logic [WORD_W-1:0]       option_reg;
    logic signed [POS_W-1:0] diff_reg;
    logic signed [POS_W-1:0] hold_pos_reg;
    logic signed [SPD_W-1:0] speed_reg;
    logic                    ff_reg;
    couple_step_t            step_reg;
    logic [15:0]             tick_cnt_reg;
    drive_cmd_t              cmd_reg;

    // =========================================================================
    // Decoding
    wire logic tick_w          = tick_cnt_reg == 16'(SAMPLE_DIV - 1);
    wire logic state_ok_w      = state_wdata < 32'h0000_0006;
    wire logic trim_on_w       = option_reg[OPT_POS_TRIM];
    wire logic lag_suppress_w  = option_reg[OPT_LAG_SUPPRESS];
    wire logic scale_on_w      = option_reg[OPT_CORR_SCALE];
    wire logic keep_ff_w       = option_reg[OPT_ZERO_FF];
    wire logic cpl_pos_w       = coupling_option_word[OPT_POS_CTRL];
    wire logic off_pos_w       = offset_option_word[OPT_POS_CTRL];
    wire logic lag_check_w     = positioning_mode || sync_ramp_type || !lag_suppress_w;
    wire logic signed [POS_W-1:0] corr_raw_w    = POS_W'(correction_value);
    wire logic signed [POS_W-1:0] gear_x_w      = POS_W'(follower_gear_factor);
    wire logic signed [POS_W-1:0] corr_scaled_w = corr_raw_w * gear_x_w;
    wire logic signed [POS_W-1:0] corr_w        = scale_on_w ? corr_scaled_w : corr_raw_w;
    wire logic signed [POS_W-1:0] lead_step_w   = POS_W'(leader.speed);
    wire logic signed [POS_W-1:0] foll_step_w   = POS_W'(speed_reg);
    wire logic signed [POS_W-1:0] corr_add_w    = correction_valid ? corr_w : '0;
    wire logic signed [POS_W-1:0] diff_next_w   = diff_reg + lead_step_w - foll_step_w
                                                + corr_add_w;
    wire logic signed [POS_W-1:0] sync_lim_w    = POS_W'(sync_speed_param);
    wire logic                    trim_hi_w     = diff_next_w > sync_lim_w;
    wire logic                    trim_lo_w     = diff_next_w < -sync_lim_w;
    wire logic signed [SPD_W-1:0] trim_spd_w    = trim_hi_w ? sync_speed_param
                                                : (trim_lo_w ? SPD_W'(-sync_speed_param)
                                                : SPD_W'(diff_next_w));
    wire logic signed [SPD_W-1:0] close_spd_w   = SPD_W'(leader.speed + trim_spd_w);

    logic signed [SPD_W-1:0] ramp_target;
    logic signed [SPD_W-1:0] ramp_rate;
    logic signed [SPD_W-1:0] ramp_out;
    logic                    ramp_done;

    assign ramp_target = (state_reg == ST_DECOUPLE)    ? '0
                       : (step_reg == CPL_SPEED_MATCH) ? leader.speed
                       : close_spd_w;
    assign ramp_rate   = (state_reg == ST_DECOUPLE) ? stop_ramp : sync_ramp_param;

    ramp_step #(.W(SPD_W)) u_ramp (
        .cur       (speed_reg),
        .target    (ramp_target),
        .step      (ramp_rate),
        .next_val  (ramp_out),
        .at_target (ramp_done)
    );

    // =========================================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        if (state_wr && state_ok_w) begin
            state_next = main_state_t'(state_wdata[2:0]);
        end else begin
            case (state_reg)
                ST_COUPLING: begin
                    if (cpl_pos_w ? sub_machine_done : (step_reg == CPL_ANGLE_CLOSE && diff_reg == 0))
                        state_next = ST_LOCKED;
                end
                ST_OFFSET: begin
                    if (sub_machine_done)
                        state_next = ST_LOCKED;
                end
                ST_DECOUPLE: begin
                    if (ramp_done && speed_reg == 0)
                        state_next = ST_FREE_SPEED;
                end
                default: state_next = state_reg;
            endcase
        end
    end

    // =========================================================================
    // Sample tick and state registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_reg <= 16'h0000;
            state_reg    <= ST_FREE_SPEED;
            option_reg   <= OPTION_RESET;
        end else begin
            tick_cnt_reg <= tick_w ? 16'h0000 : 16'(tick_cnt_reg + 16'h0001);
            state_reg    <= state_next;
            if (option_wr)
                option_reg <= option_wdata;
        end
    end

    // =========================================================================
    // Difference counter, coupling steps, hold position
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            diff_reg     <= '0;
            hold_pos_reg <= '0;
            speed_reg    <= '0;
            step_reg     <= CPL_IDLE;
            ff_reg       <= 1'b1;
        end else begin
            if (state_next == ST_FREE_HOLD && state_reg != ST_FREE_HOLD)
                hold_pos_reg <= follower.position;
            if (state_next == ST_COUPLING && state_reg != ST_COUPLING) begin
                step_reg  <= CPL_SPEED_MATCH;
                speed_reg <= follower.speed;
            end else if (state_reg == ST_FREE_SPEED) begin
                speed_reg <= follower.speed;
            end
            if (zero_point_set) begin
                ff_reg   <= keep_ff_w;
                diff_reg <= '0;
            end else if (tick_w) begin
                diff_reg <= diff_next_w;
                if ((state_reg == ST_COUPLING && !cpl_pos_w) || state_reg == ST_DECOUPLE)
                    speed_reg <= ramp_out;
                else if (state_reg == ST_LOCKED || state_reg == ST_OFFSET)
                    speed_reg <= leader.speed;
                if (state_reg == ST_COUPLING && step_reg == CPL_SPEED_MATCH && ramp_done)
                    step_reg <= CPL_ANGLE_CLOSE;
            end
            if (state_reg != ST_COUPLING && state_next != ST_COUPLING)
                step_reg <= CPL_IDLE;
            if (state_reg == ST_FREE_SPEED)
                ff_reg <= 1'b1;
        end
    end

    // =========================================================================
    // Drive command
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_reg <= '0;
        end else begin
            cmd_reg             <= '0;
            cmd_reg.feedforward <= ff_reg;
            case (state_reg)
                ST_FREE_SPEED: begin
                    cmd_reg.speed_mode   <= 1'b1;
                    cmd_reg.speed_target <= free_run_speed;
                end
                ST_FREE_HOLD: begin
                    cmd_reg.pos_mode   <= 1'b1;
                    cmd_reg.pos_target <= trim_on_w ? target_position : hold_pos_reg;
                    cmd_reg.no_ramp    <= trim_on_w;
                end
                ST_COUPLING: begin
                    cmd_reg.speed_mode   <= 1'b1;
                    cmd_reg.speed_target <= speed_reg;
                end
                ST_LOCKED: begin
                    cmd_reg.pos_mode     <= 1'b1;
                    cmd_reg.pos_target   <= follower.position + diff_reg;
                    cmd_reg.speed_target <= leader.speed;
                    cmd_reg.lag_monitor  <= lag_check_w;
                end
                ST_OFFSET: begin
                    cmd_reg.pos_mode     <= 1'b1;
                    cmd_reg.pos_target   <= follower.position + diff_reg;
                    cmd_reg.speed_target <= leader.speed;
                end
                ST_DECOUPLE: begin
                    cmd_reg.speed_mode   <= 1'b1;
                    cmd_reg.speed_target <= speed_reg;
                end
                default: cmd_reg <= '0;
            endcase
        end
    end

    // =========================================================================
    // Outputs
    assign sync_main_state   = {29'h0000_0000, state_reg};
    assign sync_option_word  = option_reg;
    assign drive_cmd         = cmd_reg;
    assign lag_distance      = diff_reg;
    assign couple_step       = step_reg;
    assign pos_ctrl_coupling = (state_reg == ST_COUPLING) && cpl_pos_w;
    assign pos_ctrl_offset   = (state_reg == ST_OFFSET) && off_pos_w;

    // =========================================================================
    // Checks
    a_state_range: assert property (@(posedge core_clk) disable iff (sys_rst)
        sync_main_state < 32'h0000_0006)
        else $error("main state out of range");

    a_free_speed: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == ST_FREE_SPEED
        |=> drive_cmd.speed_mode && drive_cmd.speed_target == $past(free_run_speed))
        else $error("free speed target wrong");

    a_hold_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == ST_FREE_HOLD && !trim_on_w
        |=> drive_cmd.pos_target == $past(hold_pos_reg))
        else $error("hold position wrong");

    a_hold_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == ST_FREE_HOLD |=> drive_cmd.pos_mode && !drive_cmd.speed_mode)
        else $error("hold not in position control");

    a_trim_direct: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == ST_FREE_HOLD && trim_on_w
        |=> drive_cmd.no_ramp && drive_cmd.pos_target == $past(target_position))
        else $error("trim not direct");

    a_lag_suppress: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == ST_LOCKED && lag_suppress_w && !positioning_mode && !sync_ramp_type
        |=> !drive_cmd.lag_monitor)
        else $error("lag monitor not suppressed");

    a_zero_ff: assert property (@(posedge core_clk) disable iff (sys_rst)
        zero_point_set && state_reg != ST_FREE_SPEED
        |=> ff_reg == $past(keep_ff_w))
        else $error("feedforward on zero point wrong");

    a_couple_order: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == ST_COUPLING && state_next == ST_LOCKED && !cpl_pos_w
        |-> step_reg == CPL_ANGLE_CLOSE)
        else $error("coupling skipped speed match");

    a_pos_coupling: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == ST_COUPLING && cpl_pos_w && !sub_machine_done && !state_wr
        |=> state_reg == ST_COUPLING)
        else $error("coupling left without sub-machine");

    a_couple_ramp: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == ST_COUPLING && state_next == ST_COUPLING && !cpl_pos_w
        |=> speed_reg - $past(speed_reg) <= $past(sync_ramp_param)
            && $past(speed_reg) - speed_reg <= $past(sync_ramp_param))
        else $error("coupling speed step too large");

    a_locked_speed: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == ST_LOCKED
        |=> drive_cmd.pos_mode && drive_cmd.speed_target == $past(leader.speed))
        else $error("locked speed wrong");

    a_stop_ramp: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == ST_DECOUPLE && state_next == ST_DECOUPLE
        |=> speed_reg - $past(speed_reg) <= $past(stop_ramp)
            && $past(speed_reg) - speed_reg <= $past(stop_ramp))
        else $error("stop ramp step too large");

endmodule : sync_follower_main_state

/* sync_follower_pkg.sv */
// Purpose: Shared constants and types for the follower main state machine
// Assumes: Speeds and positions are signed increments per sample
// Notes:   Option bit positions and state encodings used by the core
package sync_follower_pkg;

    // =========================================================================
    // Widths and reset values
    localparam int          POS_W             = 64;
    localparam int          SPD_W             = 32;
    localparam int          WORD_W            = 32;
    localparam logic [31:0] MAIN_STATE_RESET  = 32'h0000_0000;
    localparam logic [31:0] OPTION_RESET      = 32'h0000_0000;

    // =========================================================================
    // Option word bit positions
    localparam int OPT_POS_TRIM      = 0;
    localparam int OPT_LAG_SUPPRESS  = 1;
    localparam int OPT_CORR_SCALE    = 2;
    localparam int OPT_ZERO_FF       = 3;
    localparam int OPT_POS_CTRL      = 12;

    // =========================================================================
    // Timing
    localparam int CLK_MHZ           = 50;
    localparam int SAMPLE_US         = 1;
    localparam int SAMPLE_CYCLES     = SAMPLE_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_FREE_SPEED,
        ST_FREE_HOLD,
        ST_COUPLING,
        ST_LOCKED,
        ST_OFFSET,
        ST_DECOUPLE
    } main_state_t;

    typedef enum logic [1:0] {
        CPL_IDLE,
        CPL_SPEED_MATCH,
        CPL_ANGLE_CLOSE
    } couple_step_t;

    typedef struct packed {
        logic signed [SPD_W-1:0] speed;
        logic signed [POS_W-1:0] position;
    } axis_t;

    typedef struct packed {
        logic                    speed_mode;
        logic                    pos_mode;
        logic                    no_ramp;
        logic                    lag_monitor;
        logic                    feedforward;
        logic signed [SPD_W-1:0] speed_target;
        logic signed [POS_W-1:0] pos_target;
    } drive_cmd_t;

endpackage : sync_follower_pkg

/* tb_top.sv */
// Purpose: Self-checking bench for the follower main state machine
// Assumes: Sample divider shortened to 2 clocks
// Notes:   Table walk of main states, then options, coupling and decoupling
`timescale 1ns/1ps
module tb_top
    import sync_follower_pkg::*;
;
    localparam int DIV = 2;
    typedef struct packed { logic [31:0] wdata; logic [31:0] exp; } row_t;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic state_wr = 1'b0, option_wr = 1'b0, correction_valid = 1'b0;
    logic zero_point_set = 1'b0, sub_machine_done = 1'b0;
    logic positioning_mode = 1'b0, sync_ramp_type = 1'b0;
    logic [31:0] state_wdata = '0, option_wdata = '0, sync_main_state, sync_option_word;
    logic [31:0] coupling_option_word = 32'h0000_1000, offset_option_word = 32'h0000_1000;
    logic signed [31:0] free_run_speed = 32'sh0000_0007, correction_value = '0, leader_speed_set = '0;
    logic signed [31:0] sync_speed_param = 32'h0000_0002, sync_ramp_param = 32'h0000_0001;
    logic signed [31:0] stop_ramp = 32'h0000_0001;
    logic signed [15:0] follower_gear_factor = 16'h0005;
    logic signed [63:0] target_position = 64'h0000_0000_0000_0A00, lag_distance, d0;
    axis_t follower = '{speed: '0, position: 64'h0000_0000_0000_0100};
    axis_t leader;
    drive_cmd_t drive_cmd;
    logic pos_ctrl_coupling, pos_ctrl_offset;
    logic [1:0] couple_step;
    int failures = 0, checked = 0;
    row_t rows [8] = '{'{0, 0}, '{1, 1}, '{6, 1}, '{2, 2}, '{3, 3}, '{7, 3}, '{4, 4}, '{1, 1}};

    always #10 core_clk = ~core_clk;

    leader_drive_model leader_u (.core_clk(core_clk), .sys_rst(sys_rst),
        .speed_set(leader_speed_set), .leader(leader));

    sync_follower_main_state #(.SAMPLE_DIV(DIV)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .state_wr(state_wr),
        .state_wdata(state_wdata), .sync_main_state(sync_main_state),
        .option_wr(option_wr), .option_wdata(option_wdata),
        .sync_option_word(sync_option_word), .free_run_speed(free_run_speed),
        .target_position(target_position), .coupling_option_word(coupling_option_word),
        .offset_option_word(offset_option_word), .sync_speed_param(sync_speed_param),
        .sync_ramp_param(sync_ramp_param), .stop_ramp(stop_ramp),
        .follower_gear_factor(follower_gear_factor), .positioning_mode(positioning_mode),
        .sync_ramp_type(sync_ramp_type), .leader(leader), .follower(follower),
        .correction_valid(correction_valid), .correction_value(correction_value),
        .zero_point_set(zero_point_set), .sub_machine_done(sub_machine_done),
        .drive_cmd(drive_cmd), .pos_ctrl_coupling(pos_ctrl_coupling),
        .pos_ctrl_offset(pos_ctrl_offset), .lag_distance(lag_distance),
        .couple_step(couple_step));

    // =========================================================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : tick
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_state(input logic [31:0] v);
        state_wr = 1'b1;
        state_wdata = v;
        tick(1);
        state_wr = 1'b0;
    endtask : wr_state
    task automatic wr_opt(input logic [31:0] v);
        option_wr = 1'b1;
        option_wdata = v;
        tick(1);
        option_wr = 1'b0;
        tick(2);
    endtask : wr_opt
    task automatic wait_state(input logic [31:0] v, input int bound);
        for (int k = 0; k < bound && sync_main_state !== v; k++) tick(1);
        chk(sync_main_state, v);
    endtask : wait_state
    task automatic end_of_test;
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // =========================================================================
    // Watchdog
    initial begin
        #400000;
        failures++;
        end_of_test();
    end

    // =========================================================================
    // Main sequence
    initial begin
        tick(2);
        sys_rst = 1'b0;
        tick(1);
        chk(sync_main_state, 0);
        chk(sync_option_word, 0);
        chk(lag_distance, 0);
        for (int i = 0; i < 8; i++) begin
            wr_state(rows[i].wdata);
            chk(sync_main_state, rows[i].exp);
            tick(1);
            case (rows[i].exp)
                0: chk(drive_cmd.speed_target, free_run_speed);
                1: chk(drive_cmd.pos_target, follower.position);
                2: chk(pos_ctrl_coupling, 1'b1);
                3: chk(drive_cmd.lag_monitor, 1'b1);
                4: chk(pos_ctrl_offset, 1'b1);
                default: chk(1'b0, 1'b1);
            endcase
            tick(1);
        end
        wr_opt(32'h0000_0001);
        chk(sync_option_word, 32'h0000_0001);
        chk(drive_cmd.no_ramp, 1'b1);
        chk(drive_cmd.pos_target, target_position);
        wr_state(3);
        wr_opt(32'h0000_0002);
        chk(drive_cmd.lag_monitor, 1'b0);
        positioning_mode = 1'b1;
        tick(2);
        chk(drive_cmd.lag_monitor, 1'b1);
        positioning_mode = 1'b0;
        wr_state(1);
        for (int m = 0; m < 2; m++) begin
            wr_opt(m ? 32'h0000_0008 : 32'h0000_0000);
            zero_point_set = 1'b1;
            tick(1);
            zero_point_set = 1'b0;
            tick(2);
            chk(drive_cmd.feedforward, m[0]);
            chk(lag_distance, 0);
        end
        for (int m = 0; m < 2; m++) begin
            wr_opt(m ? 32'h0000_0004 : 32'h0000_0000);
            d0 = lag_distance;
            correction_valid = 1'b1;
            correction_value = 32'sd3;
            tick(DIV);
            correction_valid = 1'b0;
            tick(DIV);
            chk(lag_distance - d0, m ? 64'd15 : 64'd3);
        end
        wr_opt(32'h0000_0000);
        coupling_option_word = 32'h0000_0000;
        leader_speed_set = 32'sd4;
        wr_state(2);
        chk(couple_step, 2'd1);
        for (int k = 0; k < 500 && couple_step !== 2'd2; k++) tick(1);
        chk(couple_step, 2'd2);
        wait_state(3, 2000);
        chk(lag_distance, 0);
        tick(8);
        chk(drive_cmd.pos_mode, 1'b1);
        chk(drive_cmd.speed_target, 32'sh0000_0004);
        wr_state(5);
        tick(1);
        chk(sync_main_state, 5);
        chk(drive_cmd.speed_mode, 1'b1);
        wait_state(0, 500);
        end_of_test();
    end
endmodule : tb_top
